/* File: dv/pbws_far.sv */
// Far-side model: front switch contacts, wake sources and mains supply
module pbws_far (
    // Clock
    input  wire logic            clk,
    // Board side
    output logic                 pwr_sw_n,
    output logic                 mains_ok,
    output pbws_pkg::pbws_wake_t wake_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        pwr_sw_n = 1'b1;
        mains_ok = 1'b1;
        wake_in  = '0;
    end

    // Contacts stay closed for the whole press; no bounce is modelled
    task automatic press(input int n);
        @(posedge clk) pwr_sw_n <= 1'b0;
        repeat (n) @(posedge clk);
        pwr_sw_n <= 1'b1;
    endtask

    task automatic set_wake(input int b, input logic v);
        @(posedge clk) wake_in[b] <= v;
    endtask

    task automatic set_mains(input logic v);
        @(posedge clk) mains_ok <= v;
    endtask
endmodule // pbws_far

/* File: dv/pbws_top_tb.sv */
// Self-checking testbench for the power state sequencer
module pbws_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  clk = 1'b0;
    logic                  sys_rst;
    logic                  pwr_sw_n;
    logic                  mains_ok;
    logic                  os_sleep_req;
    pbws_pkg::pbws_wake_t  wake_in;
    pbws_pkg::pbws_cfg_t   cfg;
    pbws_pkg::pbws_state_t os_sleep_state;
    pbws_pkg::pbws_state_t power_state;
    logic                  display_asleep;
    logic                  sleep_request;
    logic                  force_off;
    logic                  usb_g3_lock;
    int                    n_errors = 0, n_tests = 0, n_sreq = 0, n_foff = 0, seed = 27;
    int                    b, s, n0, ns;
    logic [4:0]            c;
    bit                    ok;

    always #12.5 clk = ~clk;

    pbws_far far (.clk(clk), .pwr_sw_n(pwr_sw_n), .mains_ok(mains_ok), .wake_in(wake_in));

    pbws_top #(.SHORT_CYC(40), .LONG_CYC(60), .DEBOUNCE_CYC(4)) dut (
        .clk(clk), .sys_rst(sys_rst), .pwr_sw_n(pwr_sw_n), .mains_ok(mains_ok),
        .wake_in(wake_in), .cfg(cfg), .os_sleep_req(os_sleep_req),
        .os_sleep_state(os_sleep_state), .power_state(power_state),
        .display_asleep(display_asleep), .sleep_request(sleep_request),
        .force_off(force_off), .usb_g3_lock(usb_g3_lock));

    // Pulses last one cycle, so they are counted rather than polled
    always @(posedge clk) begin
        if (sleep_request === 1'b1) n_sreq++;
        if (force_off === 1'b1) n_foff++;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic settle(input logic [1:0] exp);
        for (int i = 0; i < 150 && power_state !== exp; i++) @(negedge clk);
        if (power_state !== exp) begin
            check(power_state, exp);
            complete_run();
        end
    endtask

    task automatic os_req(input int st);
        @(posedge clk) os_sleep_req <= 1'b1;
        os_sleep_state <= pbws_pkg::pbws_state_t'(st);
        @(posedge clk) os_sleep_req <= 1'b0;
    endtask

    // Reference answer: may source b wake the system from state st under settings cf
    function automatic bit wake_ok(input int sb, input int st, input logic [4:0] cf);
        bit s45, blk;
        s45 = st >= 2;
        blk = st == 3 && cf[0];
        case (sb)
            5: return 1'b1;
            4: return !blk;
            3: return !blk && !(s45 && (cf[2] || !cf[1]));
            2: return st != 3;
            1: return !blk && !(s45 && cf[2]);
            default: return 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        sys_rst        <= 1'b1;
        os_sleep_req   <= 1'b0;
        os_sleep_state <= pbws_pkg::PBWS_S0;
        cfg            <= '0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check(power_state, 8'h03);
        check(usb_g3_lock, 8'h01);
        check(display_asleep, 8'h00);
        far.press(20);
        settle(2'h0);
        check(power_state, 8'h00);
        check(usb_g3_lock, 8'h00);
        $display("test power-up press done");
        for (int k = 0; k < 36; k++) begin
            b = k % 6;
            s = 1 + (k / 6) % 3;
            c = 5'($random(seed));
            @(posedge clk) cfg <= c;
            os_req(s);
            settle(2'(s));
            far.set_wake(b, 1'b1);
            repeat (8) @(negedge clk);
            ok = wake_ok(b, s, c);
            check(power_state, 8'(ok ? 0 : s));
            if (ok) check(display_asleep, 8'(b != 1));
            far.set_wake(b, 1'b0);
            // A woken system goes back to sleep, else the press below would put it to sleep
            os_req(s);
            settle(2'(s));
            far.press(20);
            settle(2'h0);
            check(display_asleep, 8'h00);
        end
        $display("test wake sources done");
        for (int m = 0; m < 3; m++) begin
            c = 5'h10 >> m;
            s = c[3] ? 3 : (c[4] ? 2 : 1);
            @(posedge clk) cfg <= c;
            n0 = n_sreq;
            far.press(20);
            repeat (30) @(negedge clk);
            check(8'(n_sreq), 8'(n0 + 1));
            check(power_state, 8'(s));
            settle(2'(s));
            far.press(20);
            settle(2'h0);
        end
        $display("test sleep choice done");
        for (int m = 0; m < 2; m++) begin
            if (m == 1) begin
                os_req(1);
                settle(2'h1);
            end
            n0 = n_foff;
            ns = n_sreq;
            far.press(90);
            settle(2'h3);
            repeat (20) @(negedge clk);
            check(8'(n_foff), 8'(n0 + 1));
            check(8'(n_sreq), 8'(ns));
            check(display_asleep, 8'h00);
            far.press(20);
            settle(2'h0);
        end
        $display("test long press done");
        far.set_mains(1'b0);
        settle(2'h3);
        far.set_wake(5, 1'b1);
        repeat (8) @(negedge clk);
        check(power_state, 8'h03);
        check(usb_g3_lock, 8'h01);
        far.set_wake(5, 1'b0);
        far.set_mains(1'b1);
        @(posedge clk) cfg <= 5'h02;
        far.set_wake(3, 1'b1);
        repeat (8) @(negedge clk);
        check(power_state, 8'h03);
        far.set_wake(3, 1'b0);
        far.press(20);
        settle(2'h0);
        check(usb_g3_lock, 8'h00);
        $display("test mains loss done");
        complete_run();
    end
endmodule // pbws_top_tb

/* File: rtl/pbws_pkg.sv */
// Package of constants and types for the power button wake sequencer
package pbws_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned SHORT_SEC     = 4;
    localparam int unsigned LONG_SEC      = 6;
    localparam int unsigned DEBOUNCE_US   = 10_000;
    localparam int unsigned SHORT_CYC     = SHORT_SEC * CLK_HZ;
    localparam int unsigned LONG_CYC      = LONG_SEC * CLK_HZ;
    localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W         = 32;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        PBWS_S0,
        PBWS_S3,
        PBWS_S4,
        PBWS_S5
    } pbws_state_t;

    typedef struct packed {
        logic rtc;
        logic lan;
        logic usb;
        logic pcie;
        logic cir;
        logic radio;
    } pbws_wake_t;

    typedef struct packed {
        logic sleep_to_s4;  // OS choice for short press in S0: S4 else S3
        logic sleep_to_s5;  // OS choice: soft-off instead of sleep
        logic deep_sleep;   // Deep S4/S5 variant active
        logic usb_s45_en;   // Firmware enable for USB wake from S4/S5
        logic fast_startup; // OS fast startup active
    } pbws_cfg_t;

endpackage

/* File: rtl/pbws_top.sv */
// Power state sequencer: switch timing and wake source qualification
module pbws_top #(
    parameter int unsigned SHORT_CYC    = pbws_pkg::SHORT_CYC,
    parameter int unsigned LONG_CYC     = pbws_pkg::LONG_CYC,
    parameter int unsigned DEBOUNCE_CYC = pbws_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // Asynchronous board inputs
    input  wire logic                pwr_sw_n,
    input  wire logic                mains_ok,
    input  wire pbws_pkg::pbws_wake_t wake_in,
    // Settings from firmware and operating system
    input  wire pbws_pkg::pbws_cfg_t cfg,
    // OS-directed sleep entry (same clock)
    input  wire logic                os_sleep_req,
    input  wire pbws_pkg::pbws_state_t os_sleep_state,
    // Status
    output pbws_pkg::pbws_state_t    power_state,
    output logic                     display_asleep,
    output logic                     sleep_request,
    output logic                     force_off,
    output logic                     usb_g3_lock
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam int unsigned SYW = 8;
    logic [SYW-1:0] sync1;
    logic [SYW-1:0] sync2;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {~pwr_sw_n, mains_ok, wake_in};
            sync2 <= sync1;
        end
    end
    logic sw_raw;
    logic mains_s;
    pbws_pkg::pbws_wake_t wk;
    // Same field order as the capture above, so no bit position is repeated here
    assign {sw_raw, mains_s, wk} = sync2;

    // ----------------------------------------
    // Debounce and hold timer
    // ----------------------------------------
    logic                      sw_db;
    logic [pbws_pkg::CNT_W-1:0] db_cnt;
    logic [pbws_pkg::CNT_W-1:0] hold_cnt;
    logic                      long_done;
    logic                      next_sw_db;
    logic [pbws_pkg::CNT_W-1:0] next_db_cnt;
    logic [pbws_pkg::CNT_W-1:0] next_hold_cnt;
    logic                      next_long_done;
    logic                      short_evt;
    logic                      long_evt;

    always_comb begin
        next_sw_db     = sw_db;
        next_db_cnt    = '0;
        next_hold_cnt  = hold_cnt;
        next_long_done = long_done;
        short_evt      = 1'b0;
        long_evt       = 1'b0;
        // Level must stay changed for the whole window before it is believed
        if (sw_raw != sw_db) begin
            next_db_cnt = db_cnt + 1'b1;
            if (db_cnt >= DEBOUNCE_CYC - 1) begin
                next_sw_db  = sw_raw;
                next_db_cnt = '0;
            end
        end
        if (sw_db) begin
            if (!long_done) begin
                next_hold_cnt = hold_cnt + 1'b1;
                if (hold_cnt >= LONG_CYC - 1) begin
                    long_evt       = 1'b1;
                    next_long_done = 1'b1;
                end
            end
            if (!next_sw_db) begin
                // Released: between the limits nothing happens
                short_evt      = !long_done && (hold_cnt < SHORT_CYC);
                next_hold_cnt  = '0;
                next_long_done = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sw_db     <= 1'b0;
            db_cnt    <= '0;
            hold_cnt  <= '0;
            long_done <= 1'b0;
        end else begin
            sw_db     <= next_sw_db;
            db_cnt    <= next_db_cnt;
            hold_cnt  <= next_hold_cnt;
            long_done <= next_long_done;
        end
    end

    // ----------------------------------------
    // Wake qualification
    // ----------------------------------------
    logic in_sleep;
    logic s45;
    logic deep45;
    logic fs_blk;
    logic wk_rtc;
    logic wk_pcie;
    logic wk_lan;
    logic wk_usb;
    logic wk_cir;
    logic wake_ok;
    assign in_sleep = power_state != pbws_pkg::PBWS_S0;
    assign s45      = power_state == pbws_pkg::PBWS_S4 || power_state == pbws_pkg::PBWS_S5;
    assign deep45   = s45 && cfg.deep_sleep;
    assign fs_blk   = cfg.fast_startup && power_state == pbws_pkg::PBWS_S5;
    assign wk_rtc   = wk.rtc;
    assign wk_pcie  = wk.pcie && power_state != pbws_pkg::PBWS_S5;
    assign wk_lan   = wk.lan && !fs_blk;
    assign wk_usb   = wk.usb && !fs_blk && !deep45
                      && (!s45 || (cfg.usb_s45_en && !usb_g3_lock));
    assign wk_cir   = wk.cir && !fs_blk && !deep45;
    // Radio wake is left out of the sum on purpose
    assign wake_ok  = in_sleep && mains_s
                      && (wk_rtc || wk_pcie || wk_lan || wk_usb || wk_cir);

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    pbws_pkg::pbws_state_t next_power_state;
    logic                  next_display_asleep;
    logic                  next_sleep_request;
    logic                  next_force_off;
    logic                  next_usb_g3_lock;

    always_comb begin
        next_power_state    = power_state;
        next_display_asleep = display_asleep;
        next_sleep_request  = 1'b0;
        next_force_off      = 1'b0;
        next_usb_g3_lock    = usb_g3_lock;
        if (!mains_s) begin
            // Losing mains lands in soft-off; USB wake from S4/S5 stays lost until S5 is next left for S0
            next_power_state = pbws_pkg::PBWS_S5;
            next_usb_g3_lock = 1'b1;
        end else if (long_evt) begin
            next_power_state    = pbws_pkg::PBWS_S5;
            next_force_off      = 1'b1;
            next_display_asleep = 1'b0;
        end else begin
            unique case (power_state)
                pbws_pkg::PBWS_S0: begin
                    if (short_evt) begin
                        next_sleep_request = 1'b1;
                        if (cfg.sleep_to_s5) begin
                            next_power_state = pbws_pkg::PBWS_S5;
                        end else if (cfg.sleep_to_s4) begin
                            next_power_state = pbws_pkg::PBWS_S4;
                        end else begin
                            next_power_state = pbws_pkg::PBWS_S3;
                        end
                    end else if (os_sleep_req && os_sleep_state != pbws_pkg::PBWS_S0) begin
                        next_power_state = os_sleep_state;
                    end
                end
                pbws_pkg::PBWS_S3, pbws_pkg::PBWS_S4, pbws_pkg::PBWS_S5: begin
                    if (short_evt) begin
                        next_power_state    = pbws_pkg::PBWS_S0;
                        next_display_asleep = 1'b0;
                    end else if (wake_ok) begin
                        next_power_state    = pbws_pkg::PBWS_S0;
                        // Only switch and infrared wake the monitor too
                        next_display_asleep = !wk_cir;
                    end
                    if (power_state == pbws_pkg::PBWS_S5 && next_power_state == pbws_pkg::PBWS_S0) begin
                        next_usb_g3_lock = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            power_state    <= pbws_pkg::PBWS_S5;
            display_asleep <= 1'b0;
            sleep_request  <= 1'b0;
            force_off      <= 1'b0;
            usb_g3_lock    <= 1'b1;
        end else begin
            power_state    <= next_power_state;
            display_asleep <= next_display_asleep;
            sleep_request  <= next_sleep_request;
            force_off      <= next_force_off;
            usb_g3_lock    <= next_usb_g3_lock;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_long_forces_off: assert property (@(posedge clk) disable iff (sys_rst)
        long_evt && mains_s |=> power_state == pbws_pkg::PBWS_S5 && force_off)
        else $error("long press did not force soft-off");
    a_short_wakes: assert property (@(posedge clk) disable iff (sys_rst)
        short_evt && mains_s && !long_evt && in_sleep |=> power_state == pbws_pkg::PBWS_S0)
        else $error("short press did not wake");
    a_short_sleeps: assert property (@(posedge clk) disable iff (sys_rst)
        short_evt && mains_s && power_state == pbws_pkg::PBWS_S0 |=> sleep_request && in_sleep)
        else $error("short press did not request sleep");
    a_no_mains_wake: assert property (@(posedge clk) disable iff (sys_rst)
        !mains_s |=> power_state == pbws_pkg::PBWS_S5)
        else $error("woke without mains");
    a_pcie_not_s5: assert property (@(posedge clk) disable iff (sys_rst)
        power_state == pbws_pkg::PBWS_S5 && !short_evt && !wk_rtc && !wk_lan && !wk_usb
        && !wk_cir |=> power_state != pbws_pkg::PBWS_S0)
        else $error("PCIe wake left S5");
    a_rtc_dark: assert property (@(posedge clk) disable iff (sys_rst)
        mains_s && !long_evt && !short_evt && in_sleep && wk_rtc && !wk_cir
        |=> display_asleep && power_state == pbws_pkg::PBWS_S0)
        else $error("RTC wake lit display");
    a_usb_gate: assert property (@(posedge clk) disable iff (sys_rst)
        s45 && (usb_g3_lock || !cfg.usb_s45_en || cfg.deep_sleep) |-> !wk_usb)
        else $error("USB wake passed gate");
    a_fast_block: assert property (@(posedge clk) disable iff (sys_rst)
        fs_blk |-> !wk_lan && !wk_usb && !wk_cir)
        else $error("fast startup did not block");

endmodule // pbws_top
